/* hdl/ldo_regulator_control_regs.sv */
// Regulator one control registers, sequencing and regulator decode
//
// Notes on behaviour
// - Undervoltage: ignore, shut regulator, or reset device
// - Every undervoltage event raises the interrupt
// - Source field picks hardware control input(s)
// - Under hardware control, pick bit selects voltage
// - Hardware mode: low power, off, or ON mode
// - Disabled output discharged unless float bit set
// - Low-power variant bit: 50mA or 20mA
// - ON slot 0 never, 1-5 timeslot enable
// - ON slot 6/7 follow hardware enables
// - ON mode bit: normal or low power
// - Voltage code: 50mV then 100mV steps
// - Sleep codes 0,6,7 sleep in slots 5,3,1
// - Sleep codes 1-5 disable in slots 5..1
// - Hardware-enabled: codes 1-5 pick sleep slot
// - SLEEP mode bit: normal or low power
// - ON slot and voltage loadable from OTP
// - SLEEP voltage uses the same mapping
`timescale 1ns/1ns
module ldo_regulator_control_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Power sequencer
    input wire logic seqSlotStrobe,
    input wire logic [2:0] seqSlot,
    input wire logic seqGoingUp,
    input wire logic hwEnable1,
    input wire logic hwEnable2,
    input wire logic hwControl1,
    input wire logic hwControl2,
    // Configuration memory load
    input wire logic otpLoad,
    input wire logic [2:0] otpOnTimeslot,
    input wire logic [4:0] otpOnVoltageCode,
    // Regulator monitor
    input wire logic uvEvent,
    // Regulator drive
    output logic regEnable,
    output logic regLowPower,
    output logic regLowPowerVariant,
    output logic regDischarge,
    output logic [4:0] regVoltageCode,
    output logic [11:0] regMilliVolts,
    output logic [1:0] regPhase,
    // Events
    output logic uvIrq,
    output logic deviceResetReq
);
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] onCfg;
        logic [15:0] sleepCfg;
        ldo_regs_pkg::phase_t phase;
        logic waitReq;
        logic [31:0] readData;
        logic enable;
        logic lowPower;
        logic lpVariant;
        logic discharge;
        logic [4:0] vCode;
        logic [11:0] milliVolts;
        logic uvIrq;
        logic devReset;
    } state_t;

    state_t q;
    state_t d;

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] mergeWrite(input logic [15:0] old, input logic [31:0] wdata,
                                               input logic [3:0] be, input logic [15:0] mask);
        logic [15:0] merged;
        merged = old;
        if (be[0]) begin
            merged[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            merged[15:8] = wdata[15:8];
        end
        return merged & mask;
    endfunction

    // Field views of the registers
    logic [1:0] errAction;
    logic [1:0] hwcSource;
    logic hwcVoltagePick;
    logic [1:0] hwcOpMode;
    logic floatSelect;
    logic [2:0] onTimeslot;
    logic onOpMode;
    logic [4:0] onVoltageCode;
    logic [2:0] sleepTimeslot;
    logic sleepOpMode;
    logic [4:0] sleepVoltageCode;

    assign errAction = q.ctrl[ldo_regs_pkg::ERR_ACT_LSB +: 2];
    assign hwcSource = q.ctrl[ldo_regs_pkg::HWC_SRC_LSB +: 2];
    assign hwcVoltagePick = q.ctrl[ldo_regs_pkg::HWC_VPICK_BIT];
    assign hwcOpMode = q.ctrl[ldo_regs_pkg::HWC_MODE_LSB +: 2];
    assign floatSelect = q.ctrl[ldo_regs_pkg::FLOAT_BIT];
    assign onTimeslot = q.onCfg[ldo_regs_pkg::SLOT_LSB +: 3];
    assign onOpMode = q.onCfg[ldo_regs_pkg::OP_MODE_BIT];
    assign onVoltageCode = q.onCfg[ldo_regs_pkg::VCODE_LSB +: 5];
    assign sleepTimeslot = q.sleepCfg[ldo_regs_pkg::SLOT_LSB +: 3];
    assign sleepOpMode = q.sleepCfg[ldo_regs_pkg::OP_MODE_BIT];
    assign sleepVoltageCode = q.sleepCfg[ldo_regs_pkg::VCODE_LSB +: 5];

    // Sleep slot decode
    logic [2:0] sleepTargetSlot;
    logic sleepDisables;

    sleep_slot_map sleepMap (
        .sleepCode(sleepTimeslot),
        .targetSlot(sleepTargetSlot),
        .disables(sleepDisables)
    );

    // Hardware enable assignment
    logic hwEnMode;
    logic hwEnPin;
    logic hwcActive;

    assign hwEnMode = (onTimeslot == ldo_regs_pkg::SLOT_HW_EN1) || (onTimeslot == ldo_regs_pkg::SLOT_HW_EN2);
    assign hwEnPin = (onTimeslot == ldo_regs_pkg::SLOT_HW_EN1) ? hwEnable1 : hwEnable2;

    always_comb begin
        case (hwcSource)
            ldo_regs_pkg::SRC_INPUT1: hwcActive = hwControl1;
            ldo_regs_pkg::SRC_INPUT2: hwcActive = hwControl2;
            ldo_regs_pkg::SRC_EITHER: hwcActive = hwControl1 | hwControl2;
            default: hwcActive = 1'b0;
        endcase
    end

    // Regulator decode from the current state
    logic nextEnable;
    logic nextLowPower;
    logic [4:0] nextVCode;
    logic [11:0] nextMilliVolts;

    always_comb begin
        nextEnable = (q.phase != ldo_regs_pkg::PH_OFF);
        nextLowPower = 1'b0;
        nextVCode = onVoltageCode;
        if (q.phase == ldo_regs_pkg::PH_ON) begin
            nextLowPower = onOpMode;
        end else if (q.phase == ldo_regs_pkg::PH_SLEEP) begin
            nextLowPower = sleepOpMode;
            nextVCode = sleepVoltageCode;
        end
        if (hwcActive && nextEnable) begin
            nextVCode = hwcVoltagePick ? sleepVoltageCode : onVoltageCode;
            case (hwcOpMode)
                ldo_regs_pkg::HWMODE_OFF: nextEnable = 1'b0;
                ldo_regs_pkg::HWMODE_FOLLOW_ON: nextLowPower = onOpMode;
                default: nextLowPower = 1'b1;
            endcase
        end
        if (!nextEnable) begin
            nextLowPower = 1'b0;
        end
    end

    voltage_code_map voltMap (
        .code(nextVCode),
        .milliVolts(nextMilliVolts)
    );

    // Next state
    logic busReq;
    logic [15:0] hitData;
    logic hit;

    assign busReq = avs_read | avs_write;

    always_comb begin
        hit = 1'b1;
        case (avs_address)
            ldo_regs_pkg::CTRL_ADDR: hitData = q.ctrl;
            ldo_regs_pkg::ON_ADDR: hitData = q.onCfg;
            ldo_regs_pkg::SLEEP_ADDR: hitData = q.sleepCfg;
            default: begin
                hitData = 16'h0000;
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        d = q;
        d.uvIrq = 1'b0;
        d.devReset = 1'b0;
        // Bus: one wait cycle, then a single answer cycle
        d.waitReq = 1'b1;
        if (busReq && q.waitReq) begin
            d.waitReq = 1'b0;
            d.readData = {16'h0000, hitData};
        end
        if (avs_write && !q.waitReq && hit) begin
            case (avs_address)
                ldo_regs_pkg::CTRL_ADDR: d.ctrl = mergeWrite(q.ctrl, avs_writedata, avs_byteenable,
                    ldo_regs_pkg::CTRL_MASK);
                ldo_regs_pkg::ON_ADDR: d.onCfg = mergeWrite(q.onCfg, avs_writedata, avs_byteenable,
                    ldo_regs_pkg::CONFIG_MASK);
                default: d.sleepCfg = mergeWrite(q.sleepCfg, avs_writedata, avs_byteenable,
                    ldo_regs_pkg::CONFIG_MASK);
            endcase
        end
        // Configuration load overrides the ON slot and voltage fields of a same-cycle bus write
        if (otpLoad) begin
            d.onCfg[ldo_regs_pkg::SLOT_LSB +: 3] = otpOnTimeslot;
            d.onCfg[ldo_regs_pkg::VCODE_LSB +: 5] = otpOnVoltageCode;
        end
        // Sequencing
        if (hwEnMode) begin
            if (hwEnPin) begin
                d.phase = ldo_regs_pkg::PH_ON;
            end else if (q.phase == ldo_regs_pkg::PH_ON && seqSlotStrobe && seqSlot == sleepTargetSlot) begin
                d.phase = ldo_regs_pkg::PH_SLEEP;
            end
        end else if (seqSlotStrobe) begin
            if (seqGoingUp) begin
                if (onTimeslot != ldo_regs_pkg::SLOT_NEVER && seqSlot == onTimeslot) begin
                    d.phase = ldo_regs_pkg::PH_ON;
                end
            end else if (q.phase == ldo_regs_pkg::PH_ON && seqSlot == sleepTargetSlot) begin
                d.phase = sleepDisables ? ldo_regs_pkg::PH_OFF : ldo_regs_pkg::PH_SLEEP;
            end
        end
        // Undervoltage handling
        if (uvEvent) begin
            d.uvIrq = 1'b1;
            case (errAction)
                ldo_regs_pkg::ACT_SHUTDOWN: d.phase = ldo_regs_pkg::PH_OFF;
                ldo_regs_pkg::ACT_RESET: d.devReset = 1'b1;
                default: d.devReset = 1'b0;
            endcase
        end
        // Registered regulator drive
        d.enable = nextEnable;
        d.lowPower = nextLowPower;
        d.lpVariant = q.ctrl[ldo_regs_pkg::LP_VARIANT_BIT];
        d.discharge = !nextEnable && !floatSelect;
        d.vCode = nextVCode;
        d.milliVolts = nextMilliVolts;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{ctrl: ldo_regs_pkg::CTRL_RESET, onCfg: ldo_regs_pkg::ON_RESET,
                   sleepCfg: ldo_regs_pkg::SLEEP_RESET, phase: ldo_regs_pkg::PH_OFF,
                   waitReq: 1'b1, readData: 32'h0000_0000, enable: 1'b0, lowPower: 1'b0,
                   lpVariant: 1'b0, discharge: 1'b1, vCode: 5'h00, milliVolts: ldo_regs_pkg::V_BASE_MV,
                   uvIrq: 1'b0, devReset: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.readData;
    assign avs_waitrequest = q.waitReq;
    assign regEnable = q.enable;
    assign regLowPower = q.lowPower;
    assign regLowPowerVariant = q.lpVariant;
    assign regDischarge = q.discharge;
    assign regVoltageCode = q.vCode;
    assign regMilliVolts = q.milliVolts;
    assign regPhase = q.phase;
    assign uvIrq = q.uvIrq;
    assign deviceResetReq = q.devReset;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence busAsk;
        busReq && avs_waitrequest;
    endsequence

    sequence busAnswer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    AST_BUS_ONE_CYCLE_ANSWER: assert property (busAsk |=> busAnswer)
        else $error("bus request not answered in one cycle");

    AST_UV_IRQ_ALWAYS: assert property (uvEvent |=> uvIrq)
        else $error("undervoltage did not raise interrupt");

    AST_UV_SHUTDOWN: assert property (uvEvent && errAction == ldo_regs_pkg::ACT_SHUTDOWN
        |=> regPhase == ldo_regs_pkg::PH_OFF ##1 !regEnable)
        else $error("undervoltage shutdown not applied");

    AST_UV_RESET_ONLY_CODE: assert property (deviceResetReq |-> $past(uvEvent)
        && $past(errAction) == ldo_regs_pkg::ACT_RESET)
        else $error("device reset without reset action");

    AST_HWC_OFF: assert property (hwcActive && hwcOpMode == ldo_regs_pkg::HWMODE_OFF
        |=> !regEnable)
        else $error("hardware mode off left regulator on");

    AST_HWC_VPICK: assert property (hwcActive && hwcVoltagePick && regPhase != ldo_regs_pkg::PH_OFF
        && hwcOpMode != ldo_regs_pkg::HWMODE_OFF |=> regVoltageCode == $past(sleepVoltageCode))
        else $error("hardware voltage pick ignored");

    AST_DISCHARGE: assert property (!regEnable |-> regDischarge == !$past(floatSelect))
        else $error("discharge does not follow float bit");

    AST_ON_SLOT_ENABLE: assert property (seqSlotStrobe && seqGoingUp && !hwEnMode && !uvEvent
        && onTimeslot != ldo_regs_pkg::SLOT_NEVER && seqSlot == onTimeslot
        |=> regPhase == ldo_regs_pkg::PH_ON)
        else $error("regulator not enabled in its slot");

    AST_NEVER_ENABLE: assert property (!hwEnMode && onTimeslot == ldo_regs_pkg::SLOT_NEVER
        && regPhase == ldo_regs_pkg::PH_OFF |=> regPhase != ldo_regs_pkg::PH_ON)
        else $error("slot code zero enabled regulator");

    AST_SLEEP_DISABLE: assert property (seqSlotStrobe && !seqGoingUp && !hwEnMode && !uvEvent
        && regPhase == ldo_regs_pkg::PH_ON && seqSlot == sleepTargetSlot && sleepDisables
        |=> regPhase == ldo_regs_pkg::PH_OFF)
        else $error("sleep disable code did not disable");

    AST_OTP_LOAD: assert property (otpLoad |=> onTimeslot == $past(otpOnTimeslot)
        && onVoltageCode == $past(otpOnVoltageCode))
        else $error("configuration load lost");

    AST_LP_VARIANT: assert property (regLowPowerVariant == $past(q.ctrl[ldo_regs_pkg::LP_VARIANT_BIT]))
        else $error("low power variant mismatch");
endmodule

/* hdl/ldo_regs_pkg.sv */
// Shared constants and types for the regulator one control block
package ldo_regs_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [15:0] CTRL_IDX = 16'h4068;
    localparam logic [15:0] ON_IDX = 16'h4069;
    localparam logic [15:0] SLEEP_IDX = 16'h406a;
    localparam logic [17:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [17:0] ON_ADDR = {ON_IDX, 2'b00};
    localparam logic [17:0] SLEEP_ADDR = {SLEEP_IDX, 2'b00};

    // Control register fields
    localparam int ERR_ACT_LSB = 14;
    localparam int HWC_SRC_LSB = 11;
    localparam int HWC_VPICK_BIT = 10;
    localparam int HWC_MODE_LSB = 8;
    localparam int FLOAT_BIT = 7;
    localparam int LP_VARIANT_BIT = 0;
    // ON and SLEEP config fields
    localparam int SLOT_LSB = 13;
    localparam int OP_MODE_BIT = 8;
    localparam int VCODE_LSB = 0;

    // Reset values and writable bits
    localparam logic [15:0] CTRL_RESET = 16'h0200;
    localparam logic [15:0] ON_RESET = 16'h0000;
    localparam logic [15:0] SLEEP_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK = 16'hdf81;
    localparam logic [15:0] CONFIG_MASK = 16'he11f;

    // Field encodings
    localparam logic [1:0] ACT_SHUTDOWN = 2'h1;
    localparam logic [1:0] ACT_RESET = 2'h2;
    localparam logic [1:0] SRC_INPUT1 = 2'h1;
    localparam logic [1:0] SRC_INPUT2 = 2'h2;
    localparam logic [1:0] SRC_EITHER = 2'h3;
    localparam logic [1:0] HWMODE_OFF = 2'h1;
    localparam logic [1:0] HWMODE_FOLLOW_ON = 2'h3;
    localparam logic [2:0] SLOT_NEVER = 3'h0;
    localparam logic [2:0] SLOT_LAST = 3'h5;
    localparam logic [2:0] SLOT_HW_EN1 = 3'h6;
    localparam logic [2:0] SLOT_HW_EN2 = 3'h7;

    // Voltage code mapping in millivolts
    localparam logic [11:0] V_BASE_MV = 12'h384;
    localparam logic [11:0] V_FINE_STEP_MV = 12'h032;
    localparam logic [11:0] V_COARSE_BASE_MV = 12'h6a4;
    localparam logic [11:0] V_COARSE_STEP_MV = 12'h064;
    localparam logic [4:0] V_FINE_LAST = 5'h0e;
    localparam logic [4:0] V_COARSE_FIRST = 5'h0f;

    typedef enum logic [1:0] {PH_OFF, PH_ON, PH_SLEEP} phase_t;
endpackage

/* hdl/voltage_code_map.sv */
// Five-bit regulator voltage code to millivolts
`timescale 1ns/1ns
module voltage_code_map (
    // Code in, level out
    input wire logic [4:0] code,
    output logic [11:0] milliVolts
);
    always_comb begin
        if (code <= ldo_regs_pkg::V_FINE_LAST) begin
            milliVolts = 12'(ldo_regs_pkg::V_BASE_MV + ldo_regs_pkg::V_FINE_STEP_MV * {7'h00, code});
        end else begin
            milliVolts = 12'(ldo_regs_pkg::V_COARSE_BASE_MV + ldo_regs_pkg::V_COARSE_STEP_MV
                * {7'h00, 5'(code - ldo_regs_pkg::V_COARSE_FIRST)});
        end
    end
endmodule

/* hdl/sleep_slot_map.sv */
// Sleep slot code to target timeslot and disable flag
`timescale 1ns/1ns
module sleep_slot_map (
    // Code in
    input wire logic [2:0] sleepCode,
    // Decoded slot and action
    output logic [2:0] targetSlot,
    output logic disables
);
    always_comb begin
        disables = 1'b0;
        case (sleepCode)
            3'h0: targetSlot = 3'h5;
            3'h1: begin
                targetSlot = 3'h5;
                disables = 1'b1;
            end
            3'h2: begin
                targetSlot = 3'h4;
                disables = 1'b1;
            end
            3'h3: begin
                targetSlot = 3'h3;
                disables = 1'b1;
            end
            3'h4: begin
                targetSlot = 3'h2;
                disables = 1'b1;
            end
            3'h5: begin
                targetSlot = 3'h1;
                disables = 1'b1;
            end
            3'h6: targetSlot = 3'h3;
            3'h7: targetSlot = 3'h1;
            default: targetSlot = 3'h5;
        endcase
    end
endmodule

/* bench/seq_partner.sv */
// Timeslot sequencer model that drives the block's sequencer inputs
`timescale 1ns/1ns
module seq_partner (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Commands from the bench
    input wire logic go,
    input wire logic goUp,
    input wire logic slow,
    input wire logic [2:0] steps,
    // Sequencer lines
    output logic seqSlotStrobe,
    output logic [2:0] seqSlot,
    output logic seqGoingUp,
    output logic busy
);
    logic [2:0] n;
    logic [2:0] gapCnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {seqSlotStrobe, seqSlot, seqGoingUp, busy, n, gapCnt} <= '0;
        end else begin
            seqSlotStrobe <= 1'b0;
            // Slot lines toggle between the last slot and its inverse between strobes
            seqSlot <= ~seqSlot;
            if (go && !busy) begin
                busy <= 1'b1;
                seqGoingUp <= goUp;
                n <= 3'h0;
                gapCnt <= 3'h0;
            end else if (busy && gapCnt != 3'h0) begin
                gapCnt <= gapCnt - 3'h1;
            end else if (busy && n == steps) begin
                busy <= 1'b0;
            end else if (busy) begin
                seqSlotStrobe <= 1'b1;
                seqSlot <= seqGoingUp ? n + 3'h1 : 3'h5 - n;
                n <= n + 3'h1;
                gapCnt <= slow ? 3'h4 : 3'h0;
            end
        end
    end
endmodule

/* bench/tb_ldo_regulator_control_regs.sv */
// Self-checking bench for the regulator one control block
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin badCount++; $display("wrong value at %0t got %h expected %h", $time, (a), (e)); end end
module tb_ldo_regulator_control_regs;
    typedef struct packed {logic [17:0] a; logic [15:0] d; logic [3:0] be; logic [15:0] e;} row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [17:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic seqSlotStrobe, seqGoingUp, busy;
    logic [2:0] seqSlot;
    logic go = 1'b0, goUp = 1'b0, slow = 1'b0;
    logic [2:0] steps = 3'h5;
    logic hwEnable1 = 1'b0, hwEnable2 = 1'b0, hwControl1 = 1'b0, hwControl2 = 1'b0;
    logic otpLoad = 1'b0, uvEvent = 1'b0;
    logic [2:0] otpOnTimeslot = 3'h2;
    logic [4:0] otpOnVoltageCode = 5'h05;
    logic regEnable, regLowPower, regLowPowerVariant, regDischarge, uvIrq, deviceResetReq;
    logic [4:0] regVoltageCode;
    logic [11:0] regMilliVolts;
    logic [1:0] regPhase;
    logic [31:0] rd;
    int badCount = 0;
    int checks = 0;
    logic [2:0] tgt [8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
    logic [1:0] act [3] = '{2'h0, 2'h2, 2'h1};
    row_t rows [6] = '{
        '{ldo_regs_pkg::CTRL_ADDR, 16'hffff, 4'hf, 16'hdf81},
        '{ldo_regs_pkg::ON_ADDR, 16'hffff, 4'hf, 16'he11f},
        '{ldo_regs_pkg::SLEEP_ADDR, 16'hffff, 4'hf, 16'he11f},
        '{ldo_regs_pkg::ON_ADDR, 16'h0000, 4'h2, 16'h001f},
        '{ldo_regs_pkg::CTRL_ADDR, 16'h0000, 4'h1, 16'hdf00},
        '{18'h101ac, 16'hffff, 4'hf, 16'h0000}};

    always #2 sys_clk = ~sys_clk;

    ldo_regulator_control_regs dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .seqSlotStrobe, .seqSlot, .seqGoingUp, .hwEnable1,
        .hwEnable2, .hwControl1, .hwControl2, .otpLoad, .otpOnTimeslot, .otpOnVoltageCode, .uvEvent, .regEnable,
        .regLowPower, .regLowPowerVariant, .regDischarge, .regVoltageCode, .regMilliVolts, .regPhase, .uvIrq,
        .deviceResetReq);
    seq_partner seq (.sys_clk, .rst_n, .go, .goUp, .slow, .steps, .seqSlotStrobe, .seqSlot, .seqGoingUp, .busy);

    task automatic bus(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) badCount++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        bus(1'b1, a, d, 4'h3);
        tk(3);
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic runSeq(input logic up, input logic [2:0] k);
        int n;
        n = 0;
        @(posedge sys_clk);
        goUp <= up;
        slow <= up;
        steps <= k;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (busy && n < 100);
        tk(3);
    endtask

    function automatic logic [11:0] mvOf(input logic [4:0] c);
        return (c <= 5'h0e) ? 12'h384 + 12'h032 * c : 12'h6a4 + 12'h064 * (c - 5'h0f);
    endfunction

    task automatic closeOut;
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Whole sequence needs about 1250 cycles; allow far more
    initial begin
        #200000;
        badCount++;
        closeOut();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        tk(1);
        `CHK(regDischarge, 1'b1)
        `CHK(regMilliVolts, 12'h384)
        bus(1'b0, ldo_regs_pkg::CTRL_ADDR, 16'h0, 4'hf);
        `CHK(rd, 32'h0200)
        bus(1'b0, ldo_regs_pkg::SLEEP_ADDR, 16'h0, 4'hf);
        `CHK(rd, 32'h0000)
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
            bus(1'b0, rows[i].a, 16'h0, 4'hf);
            `CHK(rd, {16'h0, rows[i].e})
        end
        $display("test registers done");
        wr(ldo_regs_pkg::CTRL_ADDR, 16'h0200);
        wr(ldo_regs_pkg::ON_ADDR, 16'h000f);
        wr(ldo_regs_pkg::SLEEP_ADDR, 16'h0000);
        runSeq(1'b1, 3'h5);
        `CHK(regEnable, 1'b0)
        wr(ldo_regs_pkg::ON_ADDR, 16'h600f);
        runSeq(1'b1, 3'h5);
        `CHK(regPhase, 2'h1)
        `CHK(regLowPower, 1'b0)
        for (int c = 0; c < 32; c++) begin
            wr(ldo_regs_pkg::ON_ADDR, {3'h3, 8'h0, c[4:0]});
            `CHK(regMilliVolts, mvOf(c[4:0]))
            `CHK(regVoltageCode, c[4:0])
        end
        wr(ldo_regs_pkg::ON_ADDR, 16'h610f);
        `CHK(regLowPower, 1'b1)
        wr(ldo_regs_pkg::CTRL_ADDR, 16'h0201);
        `CHK(regLowPowerVariant, 1'b1)
        wr(ldo_regs_pkg::ON_ADDR, 16'h600f);
        $display("test power up done");
        for (int s = 0; s < 8; s++) begin
            wr(ldo_regs_pkg::SLEEP_ADDR, {s[2:0], 4'h0, 1'b1, 3'h0, 5'h1f});
            runSeq(1'b1, 3'h5);
            runSeq(1'b0, 3'h5 - tgt[s]);
            `CHK(regPhase, 2'h1)
            runSeq(1'b0, 3'h5);
            if (s >= 1 && s <= 5) begin
                `CHK(regPhase, 2'h0)
                `CHK(regDischarge, 1'b1)
                wr(ldo_regs_pkg::CTRL_ADDR, 16'h0281);
                `CHK(regDischarge, 1'b0)
                wr(ldo_regs_pkg::CTRL_ADDR, 16'h0201);
            end else begin
                `CHK(regPhase, 2'h2)
                `CHK(regMilliVolts, 12'hce4)
                `CHK(regLowPower, 1'b1)
            end
        end
        $display("test sleep done");
        wr(ldo_regs_pkg::SLEEP_ADDR, 16'h001f);
        runSeq(1'b1, 3'h5);
        for (int src = 0; src < 4; src++) begin
            for (int p = 1; p < 3; p++) begin
                wr(ldo_regs_pkg::CTRL_ADDR, {3'h0, src[1:0], 3'h5, 8'h0});
                @(posedge sys_clk);
                hwControl1 <= (p == 1);
                hwControl2 <= (p == 2);
                tk(3);
                `CHK(regEnable, !src[p - 1])
            end
        end
        wr(ldo_regs_pkg::CTRL_ADDR, 16'h1f00);
        `CHK(regMilliVolts, 12'hce4)
        `CHK(regLowPower, 1'b0)
        wr(ldo_regs_pkg::CTRL_ADDR, 16'h1800);
        `CHK(regMilliVolts, 12'h6a4)
        `CHK(regLowPower, 1'b1)
        wr(ldo_regs_pkg::CTRL_ADDR, 16'h1e00);
        `CHK(regLowPower, 1'b1)
        @(posedge sys_clk) hwControl2 <= 1'b0;
        $display("test hardware control done");
        for (int a = 0; a < 3; a++) begin
            runSeq(1'b1, 3'h5);
            wr(ldo_regs_pkg::CTRL_ADDR, {act[a], 14'h0200});
            @(posedge sys_clk) uvEvent <= 1'b1;
            @(posedge sys_clk) uvEvent <= 1'b0;
            #1;
            `CHK(uvIrq, 1'b1)
            `CHK(deviceResetReq, act[a] == 2'h2)
            tk(2);
            `CHK(uvIrq, 1'b0)
            `CHK(regEnable, act[a] != 2'h1)
        end
        $display("test undervoltage done");
        wr(ldo_regs_pkg::CTRL_ADDR, 16'h0200);
        wr(ldo_regs_pkg::ON_ADDR, 16'he00f);
        runSeq(1'b1, 3'h5);
        `CHK(regEnable, 1'b0)
        @(posedge sys_clk) hwEnable1 <= 1'b1;
        tk(3);
        `CHK(regEnable, 1'b0)
        @(posedge sys_clk) hwEnable2 <= 1'b1;
        tk(3);
        `CHK(regPhase, 2'h1)
        wr(ldo_regs_pkg::SLEEP_ADDR, 16'h4000);
        @(posedge sys_clk) hwEnable2 <= 1'b0;
        runSeq(1'b0, 3'h1);
        `CHK(regPhase, 2'h1)
        runSeq(1'b0, 3'h5);
        `CHK(regPhase, 2'h2)
        wr(ldo_regs_pkg::ON_ADDR, 16'hc00f);
        `CHK(regPhase, 2'h1)
        $display("test hardware enable done");
        @(posedge sys_clk) otpLoad <= 1'b1;
        @(posedge sys_clk) otpLoad <= 1'b0;
        bus(1'b0, ldo_regs_pkg::ON_ADDR, 16'h0, 4'hf);
        `CHK(rd, 32'h4005)
        $display("test configuration load done");
        @(posedge sys_clk) rst_n <= 1'b0;
        tk(2);
        `CHK(regPhase, 2'h0)
        `CHK(avs_waitrequest, 1'b1)
        `CHK(regDischarge, 1'b1)
        @(posedge sys_clk) rst_n <= 1'b1;
        bus(1'b0, ldo_regs_pkg::ON_ADDR, 16'h0, 4'hf);
        `CHK(rd, 32'h0000)
        bus(1'b0, ldo_regs_pkg::CTRL_ADDR, 16'h0, 4'hf);
        `CHK(rd, 32'h0200)
        $display("test mid-run reset done");
        closeOut();
    end
endmodule
